// *** design/occ_console.sv ***
module occ_console (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Panel
    input wire occ_pkg::occ_buttons_t buttons,
    input wire logic key_locked,
    input wire logic power_up,
    input wire logic bus_master_clear_line,
    input wire logic standby_power_ok,
    input wire logic [3:0] autoload_selector,
    output occ_pkg::occ_lamps_t lamps,
    // Terminal receive
    input wire logic rx_valid,
    input wire logic [6:0] rx_char,
    output logic rx_ready,
    // Terminal transmit
    output logic tx_valid,
    output logic [6:0] tx_char,
    input wire logic tx_ready,
    // CPU core side
    output occ_pkg::occ_cmd_t cmd,
    output logic cmd_valid,
    output logic cpu_running,
    output logic term_to_program,
    output logic term_irq_inhibit,
    output logic interrupt_enable_clear,
    output logic paging_enable,
    output logic paging_reset_mode,
    output logic [1:0] examine_mode,
    output logic [7:0] level_change,
    output logic level_change_valid,
    output logic auto_restart,
    output logic term_seven_even,
    output logic selftest_start,
    input wire logic selftest_done,
    input wire logic selftest_pass,
    input wire logic cpu_stop_req,
    input wire logic cpu_start_req
);
    import occ_pkg::*;

    occ_state_t state_reg, state_next;
    occ_lamps_t lamps_reg;
    logic operator_comm_mode_reg;
    logic [23:0] octal_reg;
    logic [23:0] letter_reg;
    logic [6:0] tx_char_reg;
    logic tx_valid_reg;
    logic line_start_reg;
    logic pend_quest_reg;
    logic [9:0] entry_cnt_reg;
    logic [9:0] entry_budget_reg;
    occ_cmd_t cmd_reg;
    logic cmd_valid_reg;
    logic [7:0] level_reg;
    logic level_valid_reg;
    logic ie_clear_reg;
    logic paging_en_reg;
    logic paging_rex_reg;
    logic [1:0] exam_reg;
    logic seven_even_reg;
    logic st_start_reg;
    logic sw_mc_reg;
    logic sw_stop_reg;
    logic restart_reg;
    logic auto_restart_reg;
    logic rd_done_reg;
    logic [31:0] rdata_reg;

    function automatic logic is_octal(input logic [6:0] c);
        return c >= 7'h30 && c <= 7'h37;
    endfunction : is_octal

    function automatic logic is_letter(input logic [6:0] c);
        return c >= 7'h41 && c <= 7'h59;
    endfunction : is_letter

    function automatic logic is_stop_only(input logic [6:0] c);
        return c == CH_BANG || c == CH_Z || c == CH_AMP || c == CH_DOLLAR
            || c == CH_DOT || c == CH_QUOTE || c == CH_HASH;
    endfunction : is_stop_only

    // Panel gating
    wire unlocked = !key_locked;
    wire btn_mc = buttons.master_clear && unlocked;
    wire btn_stop = buttons.stop && unlocked;
    wire btn_load = buttons.load && unlocked;
    wire btn_operator_comm_mode = buttons.operator_comm_mode && unlocked;
    wire stopped = state_reg == OCC_STOPPED;
    wire running = state_reg == OCC_RUN;
    wire in_clear = !running && !stopped;
    wire mc_trigger = btn_mc || sw_mc_reg || power_up || bus_master_clear_line;
    wire console_active = !running || operator_comm_mode_reg;
    wire stop_trigger = (btn_stop || sw_stop_reg || cpu_stop_req) && running;

    // Character classification
    wire ch_take = rx_valid && rx_ready;
    wire ch_octal = is_octal(rx_char);
    wire ch_letter = is_letter(rx_char);
    wire ch_break = rx_char == CH_AT || rx_char == CH_SPACE;
    wire ch_cr = rx_char == CH_CR;
    wire ch_slash = rx_char == CH_SLASH;
    wire ch_lt = rx_char == CH_LT;
    wire ch_star = rx_char == CH_STAR;
    wire ch_esc = rx_char == CH_ESC;
    wire ch_stop_cmd = is_stop_only(rx_char) && stopped;
    wire ch_legal = ch_octal || ch_letter || ch_break || ch_cr || ch_slash || ch_lt
        || ch_star || ch_esc || ch_stop_cmd;
    wire ch_illegal = ch_take && !ch_legal;

    logic [3:0] ch_action;
    always_comb begin
        ch_action = ACT_NONE;
        if (ch_slash) begin
            ch_action = ACT_EXAMINE;
        end else if (ch_cr) begin
            ch_action = ACT_DEPOSIT;
        end else if (ch_lt) begin
            ch_action = ACT_DUMP_SEP;
        end else if (ch_star) begin
            ch_action = ACT_PRINT_LOC;
        end else if (ch_stop_cmd) begin
            unique case (rx_char)
                CH_BANG: ch_action = ACT_START;
                CH_Z: ch_action = ACT_STEP;
                CH_AMP, CH_DOLLAR: ch_action = ACT_LOAD;
                CH_DOT: ch_action = ACT_BREAK;
                CH_QUOTE: ch_action = ACT_MANUAL;
                default: ch_action = ACT_MEMTEST;
            endcase
        end
    end

    // Console sees input only when active and its output slot is free
    // Terminal work is postponed, never waited on
    assign rx_ready = console_active && !tx_valid_reg && !pend_quest_reg && !in_clear;
    wire load_any = btn_load && stopped;
    wire issue = (ch_take && ch_action != ACT_NONE) || load_any;
    wire line_end = ch_take && (ch_cr || ch_slash || ch_break || ch_stop_cmd);
    wire esc_leave = ch_take && ch_esc && running;

    // Master clear and run sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            OCC_RUN: if (stop_trigger) state_next = OCC_STOPPED;
            OCC_LAMPS: state_next = OCC_MC_STEPS;
            OCC_MC_STEPS: state_next = OCC_SELFTEST;
            OCC_SELFTEST: if (selftest_done) state_next = OCC_LEVEL0;
            OCC_LEVEL0: state_next = OCC_STOPPED;
            OCC_STOPPED: begin
                if (cpu_start_req || restart_reg) state_next = OCC_RUN;
            end
        endcase
        if (mc_trigger) state_next = OCC_LAMPS;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= OCC_LAMPS;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lamps_reg <= '0;
            ie_clear_reg <= 1'b0;
            paging_en_reg <= 1'b0;
            paging_rex_reg <= 1'b0;
            exam_reg <= OCC_ADDR_BITS_24;
            seven_even_reg <= 1'b0;
            st_start_reg <= 1'b0;
            level_reg <= OCC_LEVEL_ZERO;
            level_valid_reg <= 1'b0;
        end else begin
            ie_clear_reg <= 1'b0;
            st_start_reg <= 1'b0;
            level_valid_reg <= 1'b0;
            if (state_next == OCC_LAMPS) begin
                lamps_reg.red <= 1'b1;
                lamps_reg.green <= 1'b1;
            end
            if (state_reg == OCC_MC_STEPS) begin
                lamps_reg.green <= 1'b0;
                ie_clear_reg <= 1'b1;
                paging_en_reg <= 1'b0;
                paging_rex_reg <= 1'b1;
                exam_reg <= OCC_ADDR_BITS_24;
                st_start_reg <= 1'b1;
            end
            if (state_reg == OCC_SELFTEST && selftest_done && selftest_pass) begin
                lamps_reg.green <= 1'b1;
                lamps_reg.red <= 1'b0;
                seven_even_reg <= 1'b1;
            end
            if (state_reg == OCC_LEVEL0) begin
                level_reg <= OCC_LEVEL_ZERO;
                level_valid_reg <= 1'b1;
            end
            lamps_reg.run <= state_next == OCC_RUN;
            lamps_reg.operator_comm_mode <= state_next != OCC_RUN
                || (operator_comm_mode_reg && !esc_leave);
        end
    end

    // Operator communication routing
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            operator_comm_mode_reg <= 1'b0;
        end else if (!running || esc_leave) begin
            operator_comm_mode_reg <= 1'b0;
        end else if (btn_operator_comm_mode) begin
            operator_comm_mode_reg <= 1'b1;
        end
    end

    // Line accumulation
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            octal_reg <= '0;
            letter_reg <= '0;
        end else if (mc_trigger || ch_illegal || (ch_take && line_end)) begin
            octal_reg <= '0;
            letter_reg <= '0;
        end else if (ch_take && ch_octal) begin
            octal_reg <= {octal_reg[20:0], rx_char[2:0]};
        end else if (ch_take && ch_letter) begin
            letter_reg <= {letter_reg[18:0], 5'(rx_char - 7'h41)};
        end
    end

    // Command out to the core; letters only applied on CR or slash
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= '0;
            cmd_valid_reg <= 1'b0;
        end else begin
            cmd_valid_reg <= issue;
            if (issue) begin
                cmd_reg.action <= load_any ? ACT_LOAD : ch_action;
                cmd_reg.octal_arg <= octal_reg;
                cmd_reg.letters <= (!load_any && (ch_cr || ch_slash)) ? letter_reg : '0;
                cmd_reg.autoload <= autoload_selector;
            end
        end
    end

    // Terminal output: hash at line start, question mark for illegal
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid_reg <= 1'b0;
            tx_char_reg <= '0;
            line_start_reg <= 1'b1;
            pend_quest_reg <= 1'b0;
        end else begin
            if (tx_valid_reg && tx_ready) begin
                tx_valid_reg <= 1'b0;
            end
            if (ch_illegal) begin
                pend_quest_reg <= 1'b1;
            end
            if (!tx_valid_reg && console_active && !in_clear) begin
                if (line_start_reg) begin
                    tx_char_reg <= CH_HASH;
                    tx_valid_reg <= 1'b1;
                    line_start_reg <= 1'b0;
                end else if (pend_quest_reg) begin
                    tx_char_reg <= CH_QUEST;
                    tx_valid_reg <= 1'b1;
                    pend_quest_reg <= 1'b0;
                    line_start_reg <= 1'b1;
                end
            end
            if (ch_take && (ch_cr || ch_break)) begin
                line_start_reg <= 1'b1;
            end
        end
    end

    // Entry time budget: each console visit is counted, restarting at the budget; no output uses the count
    wire [9:0] budget_now = (rx_valid || tx_valid_reg || pend_quest_reg)
        ? 10'(OCC_ENTRY_MAX_CYC) : 10'(OCC_ENTRY_IDLE_CYC);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            entry_cnt_reg <= '0;
            entry_budget_reg <= 10'(OCC_ENTRY_IDLE_CYC);
        end else if (!console_active || entry_cnt_reg >= entry_budget_reg) begin
            entry_cnt_reg <= '0;
            entry_budget_reg <= budget_now;
        end else begin
            entry_cnt_reg <= entry_cnt_reg + 10'h001;
        end
    end

    // Auto restart after power up, locked key only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            auto_restart_reg <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            if (power_up) begin
                auto_restart_reg <= key_locked && standby_power_ok;
            end
            restart_reg <= 1'b0;
            if (state_reg == OCC_LEVEL0 && auto_restart_reg && key_locked) begin
                restart_reg <= 1'b1;
                auto_restart_reg <= 1'b0;
            end
        end
    end

    // Avalon-MM slave: one wait cycle on reads, writes immediate
    wire wr_ctrl = avs_write && avs_address == OCC_CTRL_OFS;
    assign avs_waitrequest = avs_read && !rd_done_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sw_mc_reg <= 1'b0;
            sw_stop_reg <= 1'b0;
            rd_done_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            sw_mc_reg <= wr_ctrl && avs_writedata[0];
            sw_stop_reg <= wr_ctrl && avs_writedata[1];
            rd_done_reg <= avs_read && !rd_done_reg;
            unique case (avs_address)
                OCC_STAT_OFS: rdata_reg <= {24'h000000, lamps_reg, 1'b0,
                    operator_comm_mode_reg, running, stopped};
                OCC_CHAR_OFS: rdata_reg <= {25'h0000000, tx_char_reg};
                OCC_CMD_OFS: rdata_reg <= {28'h0000000, cmd_reg.action};
                default: rdata_reg <= '0;
            endcase
        end
    end

    assign avs_readdata = rdata_reg;
    assign lamps = lamps_reg;
    assign tx_valid = tx_valid_reg;
    assign tx_char = tx_char_reg;
    assign cmd = cmd_reg;
    assign cmd_valid = cmd_valid_reg;
    assign cpu_running = running;
    assign term_to_program = running && !operator_comm_mode_reg;
    assign term_irq_inhibit = operator_comm_mode_reg;
    assign interrupt_enable_clear = ie_clear_reg;
    assign paging_enable = paging_en_reg;
    assign paging_reset_mode = paging_rex_reg;
    assign examine_mode = exam_reg;
    assign level_change = level_reg;
    assign level_change_valid = level_valid_reg;
    assign auto_restart = restart_reg;
    assign term_seven_even = seven_even_reg;
    assign selftest_start = st_start_reg;
endmodule : occ_console

// *** design/occ_pkg.sv ***
package occ_pkg;
    // Avalon register byte offsets
    localparam logic [3:0] OCC_CTRL_OFS = 4'h0;
    localparam logic [3:0] OCC_STAT_OFS = 4'h4;
    localparam logic [3:0] OCC_CHAR_OFS = 4'h8;
    localparam logic [3:0] OCC_CMD_OFS = 4'hc;
    localparam int OCC_CLK_MHZ = 25;
    localparam int OCC_ENTRY_MAX_US = 20;
    localparam int OCC_ENTRY_IDLE_US = 6;
    localparam int OCC_ENTRY_MAX_CYC = OCC_ENTRY_MAX_US * OCC_CLK_MHZ;
    localparam int OCC_ENTRY_IDLE_CYC = OCC_ENTRY_IDLE_US * OCC_CLK_MHZ;
    localparam int OCC_SELFTEST_CYC = 8;
    localparam logic [7:0] OCC_LEVEL_ZERO = 8'h00;
    localparam logic [1:0] OCC_ADDR_BITS_24 = 2'h0;
    localparam logic [6:0] CH_HASH = 7'h23;
    localparam logic [6:0] CH_QUEST = 7'h3f;
    localparam logic [6:0] CH_CR = 7'h0d;
    localparam logic [6:0] CH_ESC = 7'h1b;
    localparam logic [6:0] CH_SLASH = 7'h2f;
    localparam logic [6:0] CH_AT = 7'h40;
    localparam logic [6:0] CH_SPACE = 7'h20;
    localparam logic [6:0] CH_LT = 7'h3c;
    localparam logic [6:0] CH_STAR = 7'h2a;
    localparam logic [6:0] CH_BANG = 7'h21;
    localparam logic [6:0] CH_Z = 7'h5a;
    localparam logic [6:0] CH_AMP = 7'h26;
    localparam logic [6:0] CH_DOLLAR = 7'h24;
    localparam logic [6:0] CH_DOT = 7'h2e;
    localparam logic [6:0] CH_QUOTE = 7'h22;
    localparam logic [3:0] ACT_NONE = 4'h0;
    localparam logic [3:0] ACT_EXAMINE = 4'h1;
    localparam logic [3:0] ACT_DEPOSIT = 4'h2;
    localparam logic [3:0] ACT_DUMP_SEP = 4'h3;
    localparam logic [3:0] ACT_PRINT_LOC = 4'h4;
    localparam logic [3:0] ACT_START = 4'h5;
    localparam logic [3:0] ACT_STEP = 4'h6;
    localparam logic [3:0] ACT_LOAD = 4'h7;
    localparam logic [3:0] ACT_BREAK = 4'h8;
    localparam logic [3:0] ACT_MANUAL = 4'h9;
    localparam logic [3:0] ACT_MEMTEST = 4'ha;
    localparam logic [3:0] ACT_MASTER_CLEAR = 4'hb;
    localparam logic [3:0] ACT_STOP = 4'hc;

    typedef enum {OCC_RUN, OCC_LAMPS, OCC_MC_STEPS, OCC_SELFTEST, OCC_LEVEL0, OCC_STOPPED}
        occ_state_t;

    typedef struct packed {
        logic master_clear;
        logic stop;
        logic load;
        logic operator_comm_mode;
    } occ_buttons_t;

    typedef struct packed {
        logic red;
        logic green;
        logic run;
        logic operator_comm_mode;
    } occ_lamps_t;

    typedef struct packed {
        logic [3:0] action;
        logic [23:0] octal_arg;
        logic [23:0] letters;
        logic [3:0] autoload;
    } occ_cmd_t;
endpackage : occ_pkg

// *** verification/occ_console_asserts.sv ***
module occ_console_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Panel
    input wire occ_pkg::occ_buttons_t buttons,
    input wire logic key_locked,
    input wire occ_pkg::occ_lamps_t lamps,
    // Terminal and core
    input wire logic rx_ready,
    input wire logic cpu_running,
    input wire logic term_to_program,
    input wire logic term_irq_inhibit,
    input wire logic interrupt_enable_clear,
    input wire logic paging_enable,
    input wire logic [1:0] examine_mode,
    input wire logic [7:0] level_change,
    input wire logic level_change_valid,
    input wire logic auto_restart,
    input wire logic term_seven_even,
    input wire logic selftest_done,
    input wire logic selftest_pass
);
    import occ_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    property p_rx_gate;
        rx_ready && cpu_running |-> !term_to_program;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("program sees console input");
    property p_route;
        term_irq_inhibit |-> !term_to_program;
    endproperty
    a_route: assert property (p_route) else $error("routing to program while held");
    property p_run_lamp;
        cpu_running [*3] |-> lamps.run;
    endproperty
    a_run_lamp: assert property (p_run_lamp) else $error("run lamp dark while running");
    property p_operator_comm_mode_lamp;
        !cpu_running [*3] ##0 rx_ready |-> lamps.operator_comm_mode;
    endproperty
    a_operator_comm_mode_lamp: assert property (p_operator_comm_mode_lamp) else $error("console lamp dark");
    property p_mc_lamps;
        $rose(buttons.master_clear) && !key_locked |-> ##[1:2] (lamps.red && lamps.green);
    endproperty
    a_mc_lamps: assert property (p_mc_lamps) else $error("clear lamps not lit");
    property p_green;
        selftest_done && selftest_pass |-> ##[1:3] (lamps.green && term_seven_even);
    endproperty
    a_green: assert property (p_green) else $error("self test pass not shown");
    property p_level0;
        level_change_valid |-> level_change == OCC_LEVEL_ZERO ##[0:4] !cpu_running;
    endproperty
    a_level0: assert property (p_level0) else $error("level change wrong");
    property p_clear;
        interrupt_enable_clear |-> ##[0:8] (examine_mode == OCC_ADDR_BITS_24 && !paging_enable);
    endproperty
    a_clear: assert property (p_clear) else $error("clear steps missing");
    property p_auto;
        auto_restart |-> key_locked;
    endproperty
    a_auto: assert property (p_auto) else $error("restart with key unlocked");
    c_share: cover property (rx_ready && cpu_running);
    c_restart: cover property (auto_restart);
    c_level: cover property (level_change_valid);
endmodule : occ_console_asserts

bind occ_console occ_console_asserts i_occ_console_asserts (.clock, .rst_n, .buttons,
    .key_locked, .lamps, .rx_ready, .cpu_running, .term_to_program, .term_irq_inhibit,
    .interrupt_enable_clear, .paging_enable, .examine_mode, .level_change,
    .level_change_valid, .auto_restart, .term_seven_even, .selftest_done, .selftest_pass);

// *** verification/occ_terminal.sv ***
module occ_terminal (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Keyboard side
    output logic rx_valid,
    output logic [6:0] rx_char,
    input wire logic rx_ready,
    // Printer side
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] seed = 32'h448981da;
    initial begin
        rx_valid = 1'h0;
        rx_char = 7'h55;
        tx_ready = 1'h0;
    end
    // Printer stalls about one cycle in four
    always @(posedge clock) begin
        tx_ready <= ($random(seed) & 32'h3) != 32'h0;
    end
    task send(input logic [6:0] ch);
        @(posedge clock);
        rx_char <= ch;
        rx_valid <= 1'h1;
        do begin
            @(posedge clock);
        end while (rx_ready !== 1'h1);
        rx_valid <= 1'h0;
        rx_char <= ~ch;
    endtask : send
endmodule : occ_terminal

// *** verification/test_operator_console_control.sv ***
module test_operator_console_control;
    timeunit 1ns;
    timeprecision 1ps;
    import occ_pkg::*;
    logic clock, rst_n, avs_read, avs_write, avs_waitrequest, key_locked, power_up;
    logic bus_master_clear_line, standby_power_ok, rx_valid, rx_ready, tx_valid, tx_ready;
    logic cmd_valid, cpu_running, term_to_program, term_irq_inhibit, interrupt_enable_clear;
    logic paging_enable, paging_reset_mode, level_change_valid, auto_restart, term_seven_even;
    logic selftest_start, selftest_done, selftest_pass, cpu_stop_req, cpu_start_req;
    logic [3:0] avs_address, autoload_selector;
    logic [31:0] avs_writedata, avs_readdata, rd, seed;
    logic [6:0] rx_char, tx_char;
    logic [1:0] examine_mode;
    logic [7:0] level_change;
    occ_buttons_t buttons;
    occ_lamps_t lamps;
    occ_cmd_t cmd;
    int mismatches, checks_done, mc_runs, hashes, restarts;
    logic [3:0] cmd_q[$];
    logic [6:0] tx_q[$];
    logic [6:0] cmd_ch[11] = '{CH_SLASH, CH_CR, CH_LT, CH_STAR, CH_Z, CH_AMP, CH_DOLLAR,
        CH_DOT, CH_QUOTE, CH_HASH, CH_BANG};
    logic [3:0] cmd_act[11] = '{ACT_EXAMINE, ACT_DEPOSIT, ACT_DUMP_SEP, ACT_PRINT_LOC,
        ACT_STEP, ACT_LOAD, ACT_LOAD, ACT_BREAK, ACT_MANUAL, ACT_MEMTEST, ACT_START};

    occ_console i_occ_console (.*);
    occ_terminal i_occ_terminal (.*);

    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    // 0 start, 1 stop, 2 bus clear line, 3 power up
    task pulse(input int k);
        {cpu_start_req, cpu_stop_req, bus_master_clear_line, power_up} <= 4'h8 >> k;
        @(posedge clock);
        {cpu_start_req, cpu_stop_req, bus_master_clear_line, power_up} <= 4'h0;
        @(posedge clock);
    endtask : pulse

    task press(input int b);
        buttons <= 4'h8 >> b;
        @(posedge clock);
        buttons <= 4'h0;
        repeat (4) @(posedge clock);
    endtask : press

    task wait_run(input logic v);
        int n;
        n = 0;
        while (cpu_running !== v && n < 500) begin
            @(posedge clock);
            n++;
        end
        check("cpu_running", cpu_running, v);
    endtask : wait_run

    task wait_mc(input int k);
        int n;
        n = 0;
        while (mc_runs < k && n < 500) begin
            @(posedge clock);
            n++;
        end
        repeat (20) @(posedge clock);
        check("clear runs", mc_runs, k);
    endtask : wait_mc

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clock);
    endtask : bus

    task exam(input logic [6:0] a, input logic [6:0] b, input logic [6:0] c);
        cmd_q.push_back(ACT_EXAMINE);
        i_occ_terminal.send(a);
        i_occ_terminal.send(b);
        i_occ_terminal.send(c);
        i_occ_terminal.send(CH_SLASH);
        repeat (4) @(posedge clock);
    endtask : exam

    // Expected results are drained here as the design produces them
    always @(posedge clock) begin
        if (cmd_valid === 1'h1) begin
            if (cmd_q.size() == 0) check("cmd extra", 1, 0);
            else check("cmd action", cmd.action, cmd_q.pop_front());
        end
        if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
            if (tx_char === CH_HASH) hashes++;
            else if (tx_q.size() == 0) check("tx extra", 1, 0);
            else check("tx char", tx_char, tx_q.pop_front());
        end
        if (auto_restart === 1'h1) restarts++;
    end

    // Self test answers a few cycles after each request, always passing
    initial forever begin
        @(posedge clock);
        if (selftest_start === 1'h1) begin
            mc_runs++;
            repeat (3) @(posedge clock);
            selftest_done <= 1'h1;
            @(posedge clock);
            selftest_done <= 1'h0;
        end
    end

    initial begin
        #2000000;
        mismatches++;
        results();
    end

    initial begin
        seed = 32'h448981da;
        {rst_n, key_locked, power_up, bus_master_clear_line, avs_read, avs_write} = 6'h0;
        {cpu_stop_req, cpu_start_req, selftest_done} = 3'h0;
        {standby_power_ok, selftest_pass} = 2'h3;
        buttons = 4'h0;
        autoload_selector = 4'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (8) @(posedge clock);
        rst_n <= 1'h1;
        wait_mc(1);
        check("green", lamps.green, 1);
        check("seven even", term_seven_even, 1);
        check("examine", examine_mode, OCC_ADDR_BITS_24);
        check("paging", paging_enable, 0);
        check("paging rex", paging_reset_mode, 1);
        check("stopped", cpu_running, 0);
        check("operator_comm_mode lamp", lamps.operator_comm_mode, 1);
        exam(7'h31, 7'h37, 7'h30);
        check("octal", cmd.octal_arg, 24'h000078);
        exam(7'h35, CH_AT, 7'h33);
        check("at break", cmd.octal_arg, 24'h000003);
        exam(7'h36, CH_SPACE, 7'h32);
        check("space break", cmd.octal_arg, 24'h000002);
        tx_q.push_back(CH_QUEST);
        exam(7'h34, 7'h39, 7'h31);
        check("after illegal", cmd.octal_arg, 24'h000001);
        exam(CH_SPACE, CH_AT, 7'h42);
        check("letters", cmd.letters, 24'h000001);
        for (int i = 0; i < 11; i++) begin
            cmd_q.push_back(cmd_act[i]);
            i_occ_terminal.send(cmd_ch[i]);
        end
        pulse(0);
        wait_run(1);
        repeat (3) @(posedge clock);
        check("run lamp", lamps.run, 1);
        check("to program", term_to_program, 1);
        check("rx idle", rx_ready, 0);
        press(3);
        check("irq inhibit", term_irq_inhibit, 1);
        check("to console", term_to_program, 0);
        check("both lamps", {lamps.run, lamps.operator_comm_mode}, 2'h3);
        tx_q.push_back(CH_QUEST);
        i_occ_terminal.send(CH_Z);
        cmd_q.push_back(ACT_EXAMINE);
        i_occ_terminal.send(CH_SLASH);
        i_occ_terminal.send(CH_ESC);
        repeat (4) @(posedge clock);
        check("escape route", term_to_program, 1);
        check("escape lamp", lamps.operator_comm_mode, 0);
        key_locked <= 1'h1;
        press(1);
        press(0);
        press(3);
        check("locked run", cpu_running, 1);
        check("locked clear", mc_runs, 1);
        check("locked operator_comm_mode", lamps.operator_comm_mode, 0);
        key_locked <= 1'h0;
        press(1);
        wait_run(0);
        i_occ_terminal.send(CH_ESC);
        repeat (4) @(posedge clock);
        check("escape stopped", lamps.operator_comm_mode, 1);
        autoload_selector <= $random(seed);
        cmd_q.push_back(ACT_LOAD);
        press(2);
        check("autoload", cmd.autoload, autoload_selector);
        pulse(0);
        press(3);
        bus(1'h1, OCC_CTRL_OFS, 32'h2);
        wait_run(0);
        pulse(0);
        wait_run(1);
        check("restart route", term_to_program, 1);
        pulse(1);
        wait_run(0);
        press(0);
        wait_mc(2);
        bus(1'h1, OCC_CTRL_OFS, 32'h1);
        wait_mc(3);
        pulse(2);
        wait_mc(4);
        bus(1'h0, OCC_STAT_OFS, 32'h0);
        check("stat", rd[7:0], 8'h51);
        bus(1'h0, 4'h2, 32'h0);
        check("unmapped", rd, 32'h0);
        key_locked <= 1'h1;
        pulse(3);
        wait_mc(5);
        check("auto restart", restarts, 1);
        check("hash seen", hashes != 0, 1);
        check("cmd left", cmd_q.size(), 0);
        check("tx left", tx_q.size(), 0);
        results();
    end
endmodule : test_operator_console_control
